//--- inc/tlp_tx_map.svh
// Constants of the transmit packet port: widths, credit field positions and timing counts.
// Assumes inclusion by bare name from design files; holds definitions only.
`ifndef TLP_TX_MAP_SVH
`define TLP_TX_MAP_SVH

`define TX_WIDE_BUS_BITS       64
`define TX_NARROW_BUS_BITS     16
`define TX_USER_CLK_MHZ        125
`define TX_HDR_CREDIT_BITS     9
`define TX_HDR_INFINITE_BIT    8
`define TX_DATA_CREDIT_BITS    13
`define TX_DATA_INFINITE_BIT   12
`define TX_MAX_PAYLOAD_BYTES   4096
`define TX_MPS_CODE_BITS       3
`define TX_BUF_DEPTH           2
`define TX_GAP_CYCLES          1

`endif

//--- inc/tlp_tx_pkg.sv
// Types used by the transmit packet port; its buffer uses none of them.
// Assumes no other package; nothing is imported by users.
package tlp_tx_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_GRANT = 3'b010,
        ST_XFER  = 3'b100
    } tx_state_type;

    typedef enum logic [2:0] {
        MPS_128 = 3'h0,
        MPS_256 = 3'h1,
        MPS_512 = 3'h2,
        MPS_1K  = 3'h3,
        MPS_2K  = 3'h4,
        MPS_4K  = 3'h5
    } mps_code_type;

endpackage

//--- hdl/tlp_tx_skid.sv
// Two-entry buffer with valid and ready on both sides, sitting in the packet word path.
// Assumes one clock and a synchronised active-low reset from the parent.
`timescale 1ns/1ps
module tlp_tx_skid #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 2
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic             i_wvalid,
    output logic                  o_wready,
    output logic [WIDTH-1:0]      o_rdata,
    output logic                  o_rvalid,
    input  wire logic             i_rready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wptr_q;
    logic [AW-1:0]    rptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    // Read data is taken straight from the entry at the read pointer, with no output register.
    assign push     = i_wvalid && o_wready;
    assign pop      = o_rvalid && i_rready;
    assign o_wready = (count_q != (AW+1)'(DEPTH));
    assign o_rvalid = (count_q != '0);
    assign o_rdata  = mem_q[rptr_q];

    // Storage is written without reset; only the pointers and the count carry control state.
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wptr_q] <= i_wdata;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + AW'(1);
            end
            if (pop) begin
                rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + AW'(1);
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_never_over: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        count_q <= (AW+1)'(DEPTH)) else $error("Buffer count passed its depth.");
endmodule

//--- hdl/tlp_tx_port.sv
// Transmit packet user port: grant handshake, packet framing, word buffering, credit outputs.
// Assumes all user signals are synchronous to i_mclk and the link side drains o_link_* words.
// Notes on behaviour
// - Everything runs on the single user clock.
// - Low reset asynchronously clears state and output registers.
// - Wide bus: first byte in top lane.
// - Narrow bus: first byte in bits 15:8.
// - Grant drops between packets, even under request.
// - Packets exclude CRCs and sequence numbers.
// - Maximum payload configurable 128 to 4K bytes.
// - Six credit counts exposed to the user.
// - Header credits nine bits, bit eight infinite.
// - Data credits thirteen bits, bit twelve infinite.
`timescale 1ns/1ps
`include "tlp_tx_map.svh"
module tlp_tx_port #(
    parameter int BUS_BITS = `TX_WIDE_BUS_BITS,
    parameter int BUF_DEPTH = `TX_BUF_DEPTH
) (
    input  wire logic                              i_mclk,
    input  wire logic                              i_rst_n,
    input  wire logic [BUS_BITS-1:0]               i_transmit_word_bus,
    input  wire logic                              i_transmit_request,
    output logic                                   o_transmit_grant,
    input  wire logic                              i_packet_start_flag,
    input  wire logic                              i_packet_end_flag,
    input  wire logic                              i_packet_discard_flag,
    input  wire logic                              i_upper_half_only_flag,
    input  wire logic [`TX_MPS_CODE_BITS-1:0]      i_max_payload_code,
    input  wire logic [3*`TX_HDR_CREDIT_BITS-1:0]  i_link_header_credits,
    input  wire logic [3*`TX_DATA_CREDIT_BITS-1:0] i_link_payload_credits,
    output logic [3*`TX_HDR_CREDIT_BITS-1:0]       o_header_credit_buses,
    output logic [3*`TX_DATA_CREDIT_BITS-1:0]      o_payload_credit_buses,
    output logic [BUS_BITS-1:0]                    o_link_word,
    output logic                                   o_link_start,
    output logic                                   o_link_end,
    output logic                                   o_link_discard,
    output logic                                   o_link_half,
    output logic                                   o_link_valid,
    input  wire logic                              i_link_ready,
    output logic                                   o_oversize_error
);
    localparam int EW = BUS_BITS + 4;
    localparam int BYTES_PER_WORD = BUS_BITS / 8;
    localparam int LEN_BITS = 14;

    logic                     rst_meta_q;
    logic                     rst_sync_n_q;
    tlp_tx_pkg::tx_state_type state_q;
    logic [LEN_BITS-1:0]      bytes_q;
    logic [LEN_BITS-1:0]      limit_bytes;
    logic                     in_fire;
    logic                     in_ready;
    logic [EW-1:0]            in_entry;
    logic [EW-1:0]            buf_rdata;
    logic                     buf_rvalid;
    logic                     out_take;
    logic                     pkt_done;

    // Maximum payload in bytes for the configured size code, used by the length check.
    function automatic logic [LEN_BITS-1:0] mps_bytes(input logic [`TX_MPS_CODE_BITS-1:0] code);
        logic [LEN_BITS-1:0] val;
        val = LEN_BITS'(`TX_MAX_PAYLOAD_BYTES);
        unique case (tlp_tx_pkg::mps_code_type'(code))
            tlp_tx_pkg::MPS_128: val = 14'h0080;
            tlp_tx_pkg::MPS_256: val = 14'h0100;
            tlp_tx_pkg::MPS_512: val = 14'h0200;
            tlp_tx_pkg::MPS_1K:  val = 14'h0400;
            tlp_tx_pkg::MPS_2K:  val = 14'h0800;
            tlp_tx_pkg::MPS_4K:  val = 14'h1000;
            default:             val = LEN_BITS'(`TX_MAX_PAYLOAD_BYTES);
        endcase
        return val;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release is synchronised so no flop leaves reset on a different edge.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_q   <= 1'b0;
            rst_sync_n_q <= 1'b0;
        end else begin
            rst_meta_q   <= 1'b1;
            rst_sync_n_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Grant state machine. Grant is given only when the buffer has room for a word and lasts one cycle;
    // later words are pushed with no room check, so a full buffer drops them; the machine returns to idle at every packet end.
    assign in_fire  = (state_q == tlp_tx_pkg::ST_XFER) && (i_packet_start_flag || bytes_q != '0
                      || i_packet_end_flag || i_packet_discard_flag);
    assign pkt_done = (state_q == tlp_tx_pkg::ST_XFER) && (i_packet_end_flag || i_packet_discard_flag);

    always_ff @(posedge i_mclk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            state_q          <= tlp_tx_pkg::ST_IDLE;
            o_transmit_grant <= 1'b0;
        end else begin
            unique case (state_q)
                tlp_tx_pkg::ST_IDLE: begin
                    if (i_transmit_request && in_ready) begin
                        state_q          <= tlp_tx_pkg::ST_GRANT;
                        o_transmit_grant <= 1'b1;
                    end
                end
                tlp_tx_pkg::ST_GRANT: begin
                    state_q          <= tlp_tx_pkg::ST_XFER;
                    o_transmit_grant <= 1'b0;
                end
                tlp_tx_pkg::ST_XFER: begin
                    if (pkt_done) begin
                        state_q <= tlp_tx_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q          <= tlp_tx_pkg::ST_IDLE;
                    o_transmit_grant <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Byte count of the packet in flight, checked against the configured maximum.
    // The check is coarse: it counts header bytes too, so it flags a packet only
    // when the whole packet exceeds the payload limit plus a sixteen-byte header allowance.
    assign limit_bytes = mps_bytes(i_max_payload_code) + LEN_BITS'(16);

    always_ff @(posedge i_mclk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            bytes_q          <= '0;
            o_oversize_error <= 1'b0;
        end else begin
            if (pkt_done) begin
                bytes_q <= '0;
            end else if (in_fire && bytes_q < limit_bytes + LEN_BITS'(BYTES_PER_WORD)) begin
                bytes_q <= bytes_q + LEN_BITS'(BYTES_PER_WORD);
            end
            o_oversize_error <= in_fire && (bytes_q >= limit_bytes);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Words pass unchanged: lane order is the user's (first byte in the top lane).
    // No CRC or sequence field is added here; the link layer appends them.
    assign in_entry = {i_packet_start_flag, i_packet_end_flag && !i_packet_discard_flag,
                       i_packet_discard_flag, i_upper_half_only_flag && (BUS_BITS == `TX_WIDE_BUS_BITS),
                       i_transmit_word_bus};

    tlp_tx_skid #(
        .WIDTH (EW),
        .DEPTH (BUF_DEPTH)
    ) u_skid (
        .i_clk    (i_mclk),
        .i_rst_n  (rst_sync_n_q),
        .i_wdata  (in_entry),
        .i_wvalid (in_fire),
        .o_wready (in_ready),
        .o_rdata  (buf_rdata),
        .o_rvalid (buf_rvalid),
        .i_rready (out_take)
    );

    // Output stage register; refilled when empty or when the link takes the word.
    assign out_take = !o_link_valid || i_link_ready;

    always_ff @(posedge i_mclk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            o_link_valid   <= 1'b0;
            o_link_word    <= '0;
            o_link_start   <= 1'b0;
            o_link_end     <= 1'b0;
            o_link_discard <= 1'b0;
            o_link_half    <= 1'b0;
        end else if (out_take) begin
            o_link_valid   <= buf_rvalid;
            o_link_word    <= buf_rdata[BUS_BITS-1:0];
            o_link_start   <= buf_rdata[EW-1] && buf_rvalid;
            o_link_end     <= buf_rdata[EW-2] && buf_rvalid;
            o_link_discard <= buf_rdata[EW-3] && buf_rvalid;
            o_link_half    <= buf_rdata[EW-4] && buf_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Credit counts are registered copies of the link's values; infinite bit passes through.
    always_ff @(posedge i_mclk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            o_header_credit_buses  <= '0;
            o_payload_credit_buses <= '0;
        end else begin
            o_header_credit_buses  <= i_link_header_credits;
            o_payload_credit_buses <= i_link_payload_credits;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_grant_pulse;
        o_transmit_grant ##1 !o_transmit_grant;
    endsequence

    a_grant_one_cycle: assert property (@(posedge i_mclk) disable iff (!rst_sync_n_q)
        o_transmit_grant |=> !o_transmit_grant) else $error("Grant held more than one cycle.");
    a_grant_needs_req: assert property (@(posedge i_mclk) disable iff (!rst_sync_n_q)
        $rose(o_transmit_grant) |-> $past(i_transmit_request)) else $error("Grant without request.");
    a_no_grant_in_pkt: assert property (@(posedge i_mclk) disable iff (!rst_sync_n_q)
        (state_q == tlp_tx_pkg::ST_XFER) |-> !o_transmit_grant) else $error("Grant inside a packet.");
    a_xfer_after_grant: assert property (@(posedge i_mclk) disable iff (!rst_sync_n_q)
        s_grant_pulse |-> state_q == tlp_tx_pkg::ST_XFER) else $error("No transfer after grant.");
    a_gap_after_end: assert property (@(posedge i_mclk) disable iff (!rst_sync_n_q)
        pkt_done |=> !o_transmit_grant ##1 1'b1) else $error("Grant right after packet end.");
    a_start_passes: assert property (@(posedge i_mclk) disable iff (!rst_sync_n_q)
        (in_fire && i_packet_start_flag && in_ready && out_take && !buf_rvalid)
        |=> ##1 (o_link_start || !i_link_ready)) else $error("Start marker lost.");
    a_discard_no_end: assert property (@(posedge i_mclk) disable iff (!rst_sync_n_q)
        o_link_discard |-> !o_link_end) else $error("End marker on discarded word.");
    // The copy is only checked once the previous edge was out of reset, since the reset edge loads zero.
    a_hdr_credit_copy: assert property (@(posedge i_mclk) disable iff (!rst_sync_n_q)
        $past(rst_sync_n_q) |-> o_header_credit_buses == $past(i_link_header_credits))
        else $error("Header credit stale.");
    a_data_credit_copy: assert property (@(posedge i_mclk) disable iff (!rst_sync_n_q)
        $past(rst_sync_n_q) |-> o_payload_credit_buses == $past(i_link_payload_credits))
        else $error("Data credit stale.");
    a_word_order: assert property (@(posedge i_mclk) disable iff (!rst_sync_n_q)
        (o_link_valid && !i_link_ready) |=> $stable(o_link_word)) else $error("Word changed under stall.");
endmodule

//--- verification/tlp_user_source.sv
// Model of the user logic that builds packets and hands them to the transmit port.
// Assumes the port samples on the rising edge; this model drives on the falling edge.
`timescale 1ns/1ps
module tlp_user_source #(
    parameter int W = 64
) (
    input  wire logic         i_clk,
    input  wire logic         i_grant,
    output logic [W-1:0]      o_word,
    output logic              o_request,
    output logic              o_start,
    output logic              o_end,
    output logic              o_discard,
    output logic              o_half
);
    // Expected link words in order: word, start, end, discard, half.
    logic [W+3:0] exp_q[$];

    initial begin
        o_word = '0;
        o_request = 1'b0;
        {o_start, o_end, o_discard, o_half} = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One packet of n words; drop abandons it, keep holds the request for a burst.
    task automatic send(input int n, input bit drop, input bit keep);
        logic [W-1:0] w;
        o_request = 1'b1;
        for (int k = 0; k < 200 && i_grant !== 1'b1; k++) @(negedge i_clk);
        if (!keep) o_request = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(negedge i_clk);
            w = W'({$urandom, $urandom});
            o_word = w;
            o_start = (i == 0);
            o_end = (i == n - 1) && !drop;
            o_discard = (i == n - 1) && drop;
            o_half = (W == 64) && (i == n - 1) && ($urandom % 2 == 1);
            exp_q.push_back({w, o_start, o_end, o_discard, o_half});
        end
        @(negedge i_clk);
        // The bus is released, so it must not keep showing the last word.
        o_word = ~w;
        {o_start, o_end, o_discard, o_half} = 4'h0;
    endtask
endmodule

//--- verification/test_tlp_transmit_user_port.sv
// Self-checking bench of the transmit port on the wide and narrow buses.
// Assumes the user-logic model notes expected words; the bench plays the link side.
`timescale 1ns/1ps
`include "tlp_tx_map.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin errors++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module test_tlp_transmit_user_port;
    logic        i_mclk = 1'b0;
    logic        i_rst_n;
    logic [63:0] word;
    logic        req, grant, st, en, dc, hf;
    logic [2:0]  mps;
    logic [26:0] hcred, ohc, hc_prev;
    logic [38:0] pcred, opc, pc_prev;
    logic [63:0] lw;
    logic        ls, le, ld, lh, lv, lr, oerr;
    logic [67:0] exp_v, got_v;
    logic [15:0] n_word, n_lw;
    logic        n_req, n_grant, n_st, n_en, n_dc, n_hf, n_ls, n_le, n_ld, n_lh, n_lv;
    logic [19:0] n_exp, n_got;
    bit          lr_hold = 1'b1;
    logic        grant_prev = 1'b0;
    bit          watch = 1'b0;
    bit          rand_ready = 1'b0;
    int          errors = 0;
    int          num_checks = 0;
    int          oversize_seen = 0;
    int          seed_v;

    // Stands in for the user clock that the core derives from the system's reference.
    always #12.5 i_mclk = ~i_mclk;

    tlp_tx_port tlp_tx_port_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_transmit_word_bus(word),
        .i_transmit_request(req), .o_transmit_grant(grant), .i_packet_start_flag(st),
        .i_packet_end_flag(en), .i_packet_discard_flag(dc), .i_upper_half_only_flag(hf),
        .i_max_payload_code(mps), .i_link_header_credits(hcred), .i_link_payload_credits(pcred),
        .o_header_credit_buses(ohc), .o_payload_credit_buses(opc), .o_link_word(lw),
        .o_link_start(ls), .o_link_end(le), .o_link_discard(ld), .o_link_half(lh),
        .o_link_valid(lv), .i_link_ready(lr), .o_oversize_error(oerr));

    tlp_user_source tlp_user_source_inst (.i_clk(i_mclk), .i_grant(grant), .o_word(word),
        .o_request(req), .o_start(st), .o_end(en), .o_discard(dc), .o_half(hf));

    // Narrow variant: the same port at sixteen bits, with a user model of its own.
    if (1) begin : narrow
        tlp_tx_port #(.BUS_BITS(16)) tlp_tx_port_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
            .i_transmit_word_bus(n_word), .i_transmit_request(n_req), .o_transmit_grant(n_grant),
            .i_packet_start_flag(n_st), .i_packet_end_flag(n_en), .i_packet_discard_flag(n_dc),
            .i_upper_half_only_flag(n_hf), .i_max_payload_code(mps), .i_link_header_credits(hcred),
            .i_link_payload_credits(pcred), .o_header_credit_buses(), .o_payload_credit_buses(),
            .o_link_word(n_lw), .o_link_start(n_ls), .o_link_end(n_le), .o_link_discard(n_ld),
            .o_link_half(n_lh), .o_link_valid(n_lv), .i_link_ready(lr), .o_oversize_error());
        tlp_user_source #(.W(16)) tlp_user_source_inst (.i_clk(i_mclk), .i_grant(n_grant), .o_word(n_word),
            .o_request(n_req), .o_start(n_st), .o_end(n_en), .o_discard(n_dc), .o_half(n_hf));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Credits and link stalls change on the falling edge; credits are random, stalls random while rand_ready is set, else set by lr_hold.
    always @(negedge i_mclk) begin
        hcred <= 27'($urandom);
        pcred <= 39'({$urandom, $urandom});
        lr <= rand_ready ? ($urandom % 2 == 1) : lr_hold;
    end

    // Watcher: each accepted link word is matched against the oldest note.
    always @(posedge i_mclk) begin
        if (watch) begin
            if (lv === 1'b1 && lr === 1'b1) begin
                if (tlp_user_source_inst.exp_q.size() == 0) begin
                    `CHK("spare link word", 1'b0, 1'b1)
                end else begin
                    exp_v = tlp_user_source_inst.exp_q.pop_front();
                    got_v = {lw, ls, le, ld, lh};
                    // Lower half carries nothing when only the upper half is valid.
                    if (exp_v[0]) got_v[35:4] = exp_v[35:4];
                    `CHK("link word", exp_v, got_v)
                end
            end
            if (n_lv === 1'b1 && lr === 1'b1) begin
                if (narrow.tlp_user_source_inst.exp_q.size() == 0) begin
                    `CHK("spare narrow word", 1'b0, 1'b1)
                end else begin
                    n_exp = narrow.tlp_user_source_inst.exp_q.pop_front();
                    n_got = {n_lw, n_ls, n_le, n_ld, n_lh};
                    `CHK("narrow word", n_exp, n_got)
                end
            end
            `CHK("header credits", hc_prev, ohc)
            `CHK("payload credits", pc_prev, opc)
            if (grant_prev) `CHK("grant pulse", 1'b0, grant)
            if (oerr === 1'b1) oversize_seen++;
        end
        grant_prev = (grant === 1'b1);
        hc_prev = hcred;
        pc_prev = pcred;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Waits, with a bound, until every noted word has left on the link.
    task automatic drain();
        for (int k = 0; k < 400 && (tlp_user_source_inst.exp_q.size() != 0
                                    || narrow.tlp_user_source_inst.exp_q.size() != 0); k++) begin
            @(negedge i_mclk);
        end
        repeat (4) @(negedge i_mclk);
        `CHK("words left", 0, tlp_user_source_inst.exp_q.size())
        `CHK("narrow words left", 0, narrow.tlp_user_source_inst.exp_q.size())
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog: far beyond the few hundred cycles the tests need.
    initial begin
        #500000;
        errors++;
        end_sim();
    end

    initial begin
        i_rst_n = 1'b0;
        mps = 3'h5;
        seed_v = $urandom(69);
        repeat (12) @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK("grant in reset", 1'b0, grant)
        `CHK("valid in reset", 1'b0, lv)
        i_rst_n = 1'b1;
        repeat (3) @(negedge i_mclk);
        watch = 1'b1;
        // Every payload limit, bursts under a held request, some packets abandoned.
        for (int i = 0; i < 24; i++) begin
            mps = 3'(i % 6);
            tlp_user_source_inst.send(1 + $urandom % 8, i % 4 == 3, i % 3 != 2);
        end
        drain();
        `CHK("no oversize", 0, oversize_seen)
        // Narrow bus: words and markers must pass whole, the half flag never set there.
        for (int i = 0; i < 6; i++) narrow.tlp_user_source_inst.send(1 + $urandom % 8, i == 4, i % 2 == 0);
        drain();
        // A 160-byte packet exceeds the smallest limit plus its header allowance.
        mps = 3'h0;
        tlp_user_source_inst.send(20, 1'b0, 1'b0);
        drain();
        `CHK("oversize flag", 1'b1, oversize_seen != 0)
        // Link stalled: the buffer fills, then drains once the link resumes.
        lr_hold = 1'b0;
        tlp_user_source_inst.send(1, 1'b0, 1'b0);
        tlp_user_source_inst.send(1, 1'b0, 1'b0);
        tlp_user_source_inst.send(1, 1'b0, 1'b0);
        repeat (20) @(negedge i_mclk);
        lr_hold = 1'b1;
        drain();
        // Random stalls under single-word packets.
        rand_ready = 1'b1;
        for (int i = 0; i < 16; i++) tlp_user_source_inst.send(1, i % 5 == 4, i % 2 == 0);
        rand_ready = 1'b0;
        @(negedge i_mclk);
        drain();
        end_sim();
    end
endmodule
